// ==== hw/sdmbc_top.sv ====
// sdmbc_top: sdram mode register, command decode and burst column sequencer
// assumes: controller drives command pins synchronous to clock_i; the
// beat stream drains through out_ready_i, and a full fifo stalls the burst
// Function
// - burst lengths 1,2,4,8 for both orders; full row only sequential
// - bursts 2/4/8 wrap inside aligned block chosen by upper column bits
// - full row burst starts at column, wraps 511 to 0 across 512 columns
// - one mode bit chooses sequential or interleaved order
// - sequential adds counter modulo length; interleaved xors counter in
// - length one uses column bits 0-8 directly, order bit ignored
// - read latency programmable as two or three cycles
// - data drive starts after edge n+m-1, data valid by edge n+m
// - write single bit set makes writes single-location, reads still burst
// - chip select high deselects; running operations continue
// - nop registers nothing and leaves running operations alone
// - load mode copies address bits 0-11 into the mode register
// - activate opens row from address in bank from bank inputs
// - mode field layout: length, order, latency, op mode, write single
// - commands decode from cs, ras, cas, we sampled together
// - read/write take column from bits 0-8, bit 10 requests auto precharge except in full row
`timescale 1ns/1ps
`default_nettype none
module sdmbc_top (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic        cs_n_i,
   input  wire logic        ras_n_i,
   input  wire logic        cas_n_i,
   input  wire logic        we_n_i,
   input  wire logic [1:0]  bank_i,
   input  wire logic [11:0] addr_i,
   input  wire logic        out_ready_i,
   output logic [11:0]      mode_o,
   output logic [3:0]       row_open_o,
   output logic [47:0]      open_rows_o,
   output logic             busy_o,
   output logic             dq_drive_o,
   output logic             dq_valid_o,
   output logic             auto_pre_o,
   output logic [13:0]      beat_o,
   output logic             beat_valid_o
);
   // =====================================================
   // command decode
   logic [3:0] cmd;
   logic       is_act, is_rd, is_wr, is_lmr, is_bst, is_pre;
   always_comb begin
      cmd    = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
      // chip select high or nop falls to no case below
      is_act = (cmd == sdmbc_pkg::CMD_ACT);
      is_rd  = (cmd == sdmbc_pkg::CMD_RD);
      is_wr  = (cmd == sdmbc_pkg::CMD_WR);
      is_lmr = (cmd == sdmbc_pkg::CMD_LMR);
      is_bst = (cmd == sdmbc_pkg::CMD_BST);
      is_pre = (cmd == sdmbc_pkg::CMD_PRE);
   end
   // =====================================================
   // mode register and row tracking
   logic [11:0] mode_r, mode_nxt;
   logic [3:0]  open_r, open_nxt;
   logic [11:0] rows_r [4];
   logic [11:0] rows_nxt [4];
   always_comb begin
      mode_nxt = mode_r;
      if (is_lmr) begin
         mode_nxt = addr_i;
      end
   end
   genvar g;
   generate
      for (g = 0; g < sdmbc_pkg::NBANK; g++) begin : g_bank
         always_comb begin
            open_nxt[g] = open_r[g];
            rows_nxt[g] = rows_r[g];
            if (is_act && bank_i == 2'(g)) begin
               open_nxt[g] = 1'b1;
               rows_nxt[g] = addr_i;
            end else if (is_pre && (addr_i[sdmbc_pkg::AP_POS] || bank_i == 2'(g))) begin
               open_nxt[g] = 1'b0;
            end
         end
         always_ff @(posedge clock_i) begin
            if (srst_i) begin
               open_r[g] <= 1'b0;
               rows_r[g] <= 12'h000;
            end else begin
               open_r[g] <= open_nxt[g];
               rows_r[g] <= rows_nxt[g];
            end
         end
      end
   endgenerate
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         mode_r <= sdmbc_pkg::MODE_RST;
      end else begin
         mode_r <= mode_nxt;
      end
   end
   // =====================================================
   // mode field decode
   logic [2:0] bl_code, rl_code;
   logic       order_il;
   logic [8:0] len_mask;
   logic       full_row;
   always_comb begin
      bl_code  = mode_r[sdmbc_pkg::BL_LSB +: 3];
      rl_code  = mode_r[sdmbc_pkg::RL_LSB +: 3];
      order_il = (mode_r[sdmbc_pkg::BT_POS] != sdmbc_pkg::BT_SEQ);
      full_row = 1'b0;
      case (bl_code)
         sdmbc_pkg::BL_1:    len_mask = 9'h000;
         sdmbc_pkg::BL_2:    len_mask = 9'h001;
         sdmbc_pkg::BL_4:    len_mask = 9'h003;
         sdmbc_pkg::BL_8:    len_mask = 9'h007;
         sdmbc_pkg::BL_FULL: begin
            len_mask = 9'h1ff;
            full_row = 1'b1;
         end
         default:            len_mask = 9'h000;
      endcase
      // full row has no interleaved form; order bit ignored there
      if (full_row) begin
         order_il = 1'b0;
      end
   end
   // =====================================================
   // burst sequencer
   sdmbc_pkg::sdmbc_state_t st_r, st_nxt;
   logic [8:0]  start_r, start_nxt;
   logic [8:0]  cnt_r, cnt_nxt;
   logic [8:0]  mask_r, mask_nxt;
   logic        il_r, il_nxt;
   logic [9:0]  left_r, left_nxt;
   logic        ap_r, ap_nxt;
   logic [1:0]  lat_r, lat_nxt;
   logic [8:0]  col;
   logic        fifo_in_ready, beat_fire, burst_end;
   logic [1:0]  lat_of_mode;
   always_comb begin
      // first beat is produced in the cycle after the read edge plus m-2 wait cycles
      lat_of_mode = (rl_code == sdmbc_pkg::RL_3) ? 2'd1 : 2'd0;
      // in-block offset, block bits kept from start
      if (il_r) begin
         col = (start_r & ~mask_r) | ((start_r ^ cnt_r) & mask_r);
      end else begin
         col = (start_r & ~mask_r) | ((start_r + cnt_r) & mask_r);
      end
      beat_fire = (st_r != sdmbc_pkg::SDMBC_IDLE) && (lat_r == 2'd0) && fifo_in_ready;
      burst_end = beat_fire && (left_r == 10'h001);
      st_nxt    = st_r;
      start_nxt = start_r;
      cnt_nxt   = cnt_r;
      mask_nxt  = mask_r;
      il_nxt    = il_r;
      left_nxt  = left_r;
      ap_nxt    = ap_r;
      lat_nxt   = (lat_r != 2'd0) ? 2'(lat_r - 2'd1) : lat_r;
      if (beat_fire) begin
         cnt_nxt  = 9'(cnt_r + 9'h001);
         left_nxt = 10'(left_r - 10'h001);
      end
      if (burst_end || is_bst) begin
         st_nxt = sdmbc_pkg::SDMBC_IDLE;
      end
      if (is_rd || is_wr) begin
         st_nxt    = is_rd ? sdmbc_pkg::SDMBC_READ : sdmbc_pkg::SDMBC_WRITE;
         start_nxt = addr_i[8:0];
         cnt_nxt   = 9'h000;
         ap_nxt    = addr_i[sdmbc_pkg::AP_POS] && !full_row;
         lat_nxt   = is_rd ? lat_of_mode : 2'd0;
         if (is_wr && mode_r[sdmbc_pkg::WS_POS]) begin
            mask_nxt = 9'h000;
            il_nxt   = 1'b0;
            left_nxt = 10'h001;
         end else begin
            mask_nxt = len_mask;
            il_nxt   = order_il && (len_mask != 9'h000);
            left_nxt = full_row ? sdmbc_pkg::ROW_BEATS : 10'({1'b0, len_mask} + 10'h001);
         end
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         st_r    <= sdmbc_pkg::SDMBC_IDLE;
         start_r <= 9'h000;
         cnt_r   <= 9'h000;
         mask_r  <= 9'h000;
         il_r    <= 1'b0;
         left_r  <= 10'h000;
         ap_r    <= 1'b0;
         lat_r   <= 2'd0;
      end else begin
         st_r    <= st_nxt;
         start_r <= start_nxt;
         cnt_r   <= cnt_nxt;
         mask_r  <= mask_nxt;
         il_r    <= il_nxt;
         left_r  <= left_nxt;
         ap_r    <= ap_nxt;
         lat_r   <= lat_nxt;
      end
   end
   // =====================================================
   // beat fifo: a stalled drain holds the burst, which stretches latency
   logic [13:0] fifo_q;
   logic        fifo_v;
   sdmbc_fifo #(
      .WIDTH (sdmbc_pkg::FIFO_W),
      .DEPTH (sdmbc_pkg::FIFO_D)
   ) u_fifo (
      .clock_i     (clock_i),
      .srst_i      (srst_i),
      .in_data_i   ({st_r == sdmbc_pkg::SDMBC_WRITE, ap_r && (left_r == 10'h001),
                     burst_end, 2'b00, col}),
      .in_valid_i  (beat_fire),
      .in_ready_o  (fifo_in_ready),
      .out_data_o  (fifo_q),
      .out_valid_o (fifo_v),
      .out_ready_i (out_ready_i)
   );
   // =====================================================
   // registered outputs
   logic [47:0] rows_flat;
   always_comb begin
      for (int i = 0; i < sdmbc_pkg::NBANK; i++) begin
         rows_flat[i*12 +: 12] = rows_nxt[i];
      end
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         mode_o       <= sdmbc_pkg::MODE_RST;
         row_open_o   <= 4'h0;
         open_rows_o  <= 48'h0;
         busy_o       <= 1'b0;
         dq_drive_o   <= 1'b0;
         dq_valid_o   <= 1'b0;
         auto_pre_o   <= 1'b0;
         beat_o       <= 14'h0;
         beat_valid_o <= 1'b0;
      end else begin
         mode_o       <= mode_nxt;
         row_open_o   <= open_nxt;
         open_rows_o  <= rows_flat;
         busy_o       <= (st_nxt != sdmbc_pkg::SDMBC_IDLE);
         dq_drive_o   <= (st_r == sdmbc_pkg::SDMBC_READ) && (lat_r == 2'd0);
         dq_valid_o   <= beat_fire && (st_r == sdmbc_pkg::SDMBC_READ);
         auto_pre_o   <= burst_end && ap_r;
         beat_o       <= fifo_q;
         beat_valid_o <= fifo_v && out_ready_i;
      end
   end
endmodule
`default_nettype wire

// ==== hw/sdmbc_pkg.sv ====
// sdmbc_pkg: constants for the sdram mode, burst and command block
// assumes: used by sdmbc_top, which sizes sdmbc_fifo from it, and the verif files, referenced as sdmbc_pkg::name
package sdmbc_pkg;
   // =====================================================
   // widths
   localparam int ADDR_W    = 12;
   localparam int COL_W     = 9;
   localparam int BANK_W    = 2;
   localparam int NBANK     = 4;
   localparam int FIFO_W    = 14;
   localparam int FIFO_D    = 8;
   // =====================================================
   // mode register field positions
   localparam int BL_LSB    = 0;
   localparam int BT_POS    = 3;
   localparam int RL_LSB    = 4;
   localparam int OPM_LO    = 7;
   localparam int OPM_HI    = 8;
   localparam int WS_POS    = 9;
   localparam logic [11:0] MODE_RST = 12'h000;
   // =====================================================
   // field encodings
   localparam logic [2:0] BL_1    = 3'h0;
   localparam logic [2:0] BL_2    = 3'h1;
   localparam logic [2:0] BL_4    = 3'h2;
   localparam logic [2:0] BL_8    = 3'h3;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] RL_2    = 3'h2;
   localparam logic [2:0] RL_3    = 3'h3;
   localparam logic       BT_SEQ  = 1'b0;
   localparam int         AP_POS  = 10;
   localparam logic [9:0] ROW_BEATS = 10'h200;
   // =====================================================
   // commands {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_NOP   = 4'h7;
   localparam logic [3:0] CMD_ACT   = 4'h3;
   localparam logic [3:0] CMD_RD    = 4'h5;
   localparam logic [3:0] CMD_WR    = 4'h4;
   localparam logic [3:0] CMD_BST   = 4'h6;
   localparam logic [3:0] CMD_PRE   = 4'h2;
   localparam logic [3:0] CMD_LMR   = 4'h0;
   typedef enum logic [1:0] {
      SDMBC_IDLE  = 2'b00,
      SDMBC_READ  = 2'b01,
      SDMBC_WRITE = 2'b10
   } sdmbc_state_t;
endpackage

// ==== hw/sdmbc_fifo.sv ====
// sdmbc_fifo: synchronous fifo with valid/ready on both sides
// assumes: one clock, synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sdmbc_fifo #(
   parameter int WIDTH = 14,
   parameter int DEPTH = 8
) (
   input  wire logic             clock_i,
   input  wire logic             srst_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]      cnt_r, cnt_nxt;
   logic             push, pop;
   // =====================================================
   // pointers and count
   always_comb begin
      push    = in_valid_i && (cnt_r != AW'(0) + (AW+1)'(DEPTH));
      pop     = out_ready_i && (cnt_r != '0);
      wp_nxt  = push ? AW'(wp_r + 1'b1) : wp_r;
      rp_nxt  = pop ? AW'(rp_r + 1'b1) : rp_r;
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_r[wp_r] <= in_data_i;
      end
   end
   assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid_o = (cnt_r != '0);
   assign out_data_o  = mem_r[rp_r];
endmodule
`default_nettype wire

// ==== verif/sdmbc_top_properties.sv ====
// sdmbc_top_properties: concurrent checks on the sdmbc_top ports
// assumes: bound onto sdmbc_top from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module sdmbc_top_properties (
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic        cs_n_i,
   input wire logic        ras_n_i,
   input wire logic        cas_n_i,
   input wire logic        we_n_i,
   input wire logic [1:0]  bank_i,
   input wire logic [11:0] addr_i,
   input wire logic        out_ready_i,
   input wire logic [11:0] mode_o,
   input wire logic [3:0]  row_open_o,
   input wire logic [47:0] open_rows_o,
   input wire logic        busy_o,
   input wire logic        dq_drive_o,
   input wire logic        dq_valid_o,
   input wire logic        auto_pre_o,
   input wire logic [13:0] beat_o,
   input wire logic        beat_valid_o
);
   // ==========================================
   // command decode
   logic [3:0] cmd;
   logic       rd_idle;
   assign cmd = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
   assign rd_idle = cmd == sdmbc_pkg::CMD_RD && !busy_o;
   // ==========================================
   // assertions
   mode_load_a: assert property (@(posedge clock_i) disable iff (srst_i)
      cmd == sdmbc_pkg::CMD_LMR |=> mode_o == $past(addr_i)) else $error("mode not loaded");
   deselect_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
      cs_n_i |=> $stable(mode_o)) else $error("deselect changed mode");
   nop_hold_a: assert property (@(posedge clock_i) disable iff (srst_i)
      cmd == sdmbc_pkg::CMD_NOP |=> $stable(mode_o)) else $error("nop changed mode");
   act_open_a: assert property (@(posedge clock_i) disable iff (srst_i)
      cmd == sdmbc_pkg::CMD_ACT |=> row_open_o[$past(bank_i)]
      && open_rows_o[$past(bank_i)*12 +: 12] == $past(addr_i)) else $error("row not opened");
   pre_all_a: assert property (@(posedge clock_i) disable iff (srst_i)
      cmd == sdmbc_pkg::CMD_PRE && addr_i[10] |=> row_open_o == 4'h0) else $error("rows open");
   lat_two_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rd_idle && mode_o[6:4] != sdmbc_pkg::RL_3 |=> !dq_valid_o ##1 dq_valid_o)
      else $error("latency two wrong");
   lat_three_a: assert property (@(posedge clock_i) disable iff (srst_i)
      rd_idle && mode_o[6:4] == sdmbc_pkg::RL_3 |=> !dq_valid_o [*2] ##1 dq_valid_o)
      else $error("latency three wrong");
   drive_win_a: assert property (@(posedge clock_i) disable iff (srst_i)
      dq_valid_o |-> dq_drive_o) else $error("data valid outside drive window");
   reset_clear_a: assert property (@(posedge clock_i)
      srst_i |=> mode_o == sdmbc_pkg::MODE_RST && row_open_o == 4'h0 && !busy_o)
      else $error("reset left state");
   cover property (@(posedge clock_i) cmd == sdmbc_pkg::CMD_LMR);
   cover property (@(posedge clock_i) rd_idle && mode_o[6:4] == sdmbc_pkg::RL_3);
   cover property (@(posedge clock_i) beat_valid_o && beat_o[12]);
endmodule
`default_nettype wire

// ==== verif/sdmbc_ctrl_model.sv ====
// sdmbc_ctrl_model: memory controller driving command and address pins
// assumes: pins change at the falling edge, so the rising edge sees them settled
`timescale 1ns/1ps
`default_nettype none
module sdmbc_ctrl_model #(
   parameter int MODE_SET_DELAY = 2
) (
   input  wire logic clock_i,
   output logic      cs_n_o,
   output logic      ras_n_o,
   output logic      cas_n_o,
   output logic      we_n_o,
   output logic [1:0]  bank_o,
   output logic [11:0] addr_o
);
   logic nop_fill;
   initial begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = sdmbc_pkg::CMD_NOP;
      bank_o = 2'h0;
      addr_o = 12'h000;
      nop_fill = 1'b1;
   end
   // ==========================================
   // command tasks
   task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a);
      @(negedge clock_i);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = c;
      bank_o = b;
      addr_o = a;
   endtask
   // deselect shows a load-mode pin shape and a flipped address: no kinder than a real bus
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clock_i);
         {cs_n_o, ras_n_o, cas_n_o, we_n_o} = nop_fill ? sdmbc_pkg::CMD_NOP : 4'h8;
         addr_o = ~addr_o;
      end
   endtask
   // 40 MHz is under every latency-two limit, so either code is legal
   task automatic load_mode(input logic [11:0] m);
      issue(sdmbc_pkg::CMD_PRE, 2'h0, 12'h400);
      issue(sdmbc_pkg::CMD_LMR, 2'h0, m & 12'h27f);
      idle(MODE_SET_DELAY);
   endtask
endmodule
`default_nettype wire

// ==== verif/sdmbc_top_tb.sv ====
// sdmbc_top_tb: burst order, latency, command and fifo scenarios
// assumes: sdmbc_ctrl_model drives the command pins, the bench drives reset and drain
`timescale 1ns/1ps
`default_nettype none
module sdmbc_top_tb;
   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        out_ready_i = 1'b1;
   wire logic   cs_n, ras_n, cas_n, we_n;
   wire logic [1:0]  bank;
   wire logic [11:0] addr;
   logic [11:0] mode_o;
   logic [3:0]  row_open_o;
   logic [47:0] open_rows_o;
   logic        busy_o, dq_drive_o, dq_valid_o, auto_pre_o, beat_valid_o;
   logic [13:0] beat_o;
   logic [13:0] q[$];
   int          n_mismatch = 0;
   int          n_checks = 0;
   int          cyc = 0;
   always #12.5 clock_i = ~clock_i;
   sdmbc_ctrl_model sdmbc_ctrl_model_i (.clock_i(clock_i), .cs_n_o(cs_n), .ras_n_o(ras_n),
      .cas_n_o(cas_n), .we_n_o(we_n), .bank_o(bank), .addr_o(addr));
   sdmbc_top sdmbc_top_i (.clock_i(clock_i), .srst_i(srst_i), .cs_n_i(cs_n), .ras_n_i(ras_n),
      .cas_n_i(cas_n), .we_n_i(we_n), .bank_i(bank), .addr_i(addr), .out_ready_i(out_ready_i),
      .mode_o(mode_o), .row_open_o(row_open_o), .open_rows_o(open_rows_o), .busy_o(busy_o),
      .dq_drive_o(dq_drive_o), .dq_valid_o(dq_valid_o), .auto_pre_o(auto_pre_o),
      .beat_o(beat_o), .beat_valid_o(beat_valid_o));
   always @(posedge clock_i) if (beat_valid_o === 1'b1) q.push_back(beat_o);
   // ==========================================
   // helpers
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // expected runs far beyond the ~400 cycles the tests need
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         close_out();
      end
   end
   task automatic chk(input logic [13:0] got, input logic [13:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [8:0] ecol(logic [8:0] s, int len, logic bt, int i);
      logic [8:0] m;
      m = 9'(len - 1);
      if (bt) return (s & ~m) | ((s ^ 9'(i)) & m);
      return (s & ~m) | ((s + 9'(i)) & m);
   endfunction
   task automatic wait_beats(input int n);
      int k;
      k = 0;
      while (q.size() < n && k < 2000) begin
         @(negedge clock_i);
         k++;
      end
   endtask
   task automatic burst(input logic [2:0] blc, input int len, input logic bt, input logic ws,
                        input logic wr, input logic ap, input logic [8:0] s, input int n);
      logic [11:0] m;
      m = {2'b00, ws, 2'b00, (bt ? sdmbc_pkg::RL_3 : sdmbc_pkg::RL_2), bt, blc};
      sdmbc_ctrl_model_i.nop_fill = ~bt;
      sdmbc_ctrl_model_i.load_mode(m);
      chk({2'b00, mode_o}, {2'b00, m});
      q.delete();
      sdmbc_ctrl_model_i.issue(sdmbc_pkg::CMD_ACT, 2'h1, 12'h5a3);
      sdmbc_ctrl_model_i.idle(1);
      chk({1'b0, row_open_o[1], open_rows_o[23:12]}, {2'b01, 12'h5a3});
      sdmbc_ctrl_model_i.issue(wr ? sdmbc_pkg::CMD_WR : sdmbc_pkg::CMD_RD, 2'h1,
                               {1'b0, ap, 1'b0, s});
      sdmbc_ctrl_model_i.idle(1);
      wait_beats(n);
      sdmbc_ctrl_model_i.idle(12);
      chk(14'(q.size()), 14'(n));
      for (int i = 0; i < n; i++)
         chk(q[i], {wr, ap && i == n - 1, i == n - 1, 2'b00, ecol(s, len, bt, i)});
      chk({2'b00, mode_o}, {2'b00, m});
      $display("test done: length code %h order %h write %h", blc, bt, wr);
   endtask
   // ==========================================
   // main sequence
   initial begin
      repeat (20) @(negedge clock_i);
      srst_i = 1'b0;
      for (int b = 0; b < 4; b++)
         for (int t = 0; t < 2; t++) burst(3'(b), 1 << b, t[0], 1'b0, 1'b0, t[0], 9'h1a5, 1 << b);
      burst(sdmbc_pkg::BL_8, 8, 1'b0, 1'b1, 1'b1, 1'b1, 9'h0b3, 1);
      burst(sdmbc_pkg::BL_8, 8, 1'b0, 1'b1, 1'b0, 1'b0, 9'h0b3, 8);
      burst(sdmbc_pkg::BL_8, 8, 1'b1, 1'b0, 1'b1, 1'b0, 9'h0b3, 8);
      sdmbc_ctrl_model_i.load_mode({5'h00, sdmbc_pkg::RL_2, sdmbc_pkg::BT_SEQ, sdmbc_pkg::BL_FULL});
      q.delete();
      out_ready_i = 1'b0;
      sdmbc_ctrl_model_i.issue(sdmbc_pkg::CMD_ACT, 2'h2, 12'h0c1);
      sdmbc_ctrl_model_i.issue(sdmbc_pkg::CMD_RD, 2'h2, 12'h1fc);
      sdmbc_ctrl_model_i.idle(40);
      chk({q.size() == 0, busy_o}, 14'h0003);
      out_ready_i = 1'b1;
      wait_beats(12);
      sdmbc_ctrl_model_i.issue(sdmbc_pkg::CMD_BST, 2'h2, 12'h000);
      sdmbc_ctrl_model_i.idle(30);
      for (int i = 0; i < 12; i++) chk({5'h00, q[i][8:0]}, {5'h00, 9'h1fc + 9'(i)});
      chk({13'h0000, busy_o}, 14'h0000);
      $display("test done: full row wrap, stall and terminate");
      srst_i = 1'b1;
      sdmbc_ctrl_model_i.idle(2);
      srst_i = 1'b0;
      chk({2'b00, mode_o}, {2'b00, sdmbc_pkg::MODE_RST});
      close_out();
   end
endmodule
bind sdmbc_top sdmbc_top_properties sdmbc_top_properties_i (.clock_i(clock_i), .srst_i(srst_i),
   .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .bank_i(bank_i),
   .addr_i(addr_i), .out_ready_i(out_ready_i), .mode_o(mode_o), .row_open_o(row_open_o),
   .open_rows_o(open_rows_o), .busy_o(busy_o), .dq_drive_o(dq_drive_o), .dq_valid_o(dq_valid_o),
   .auto_pre_o(auto_pre_o), .beat_o(beat_o), .beat_valid_o(beat_valid_o));
`default_nettype wire
